// >>> hw/dpm_pin_mux.sv
// pin-function and operating-mode multiplexer of the signal processor
// Behaviour
// - strap C at reset: 0 full, 1 host
// - strap pins only read during reset
// - full enables byte DMA, host enables host port
// - shared pins carry only the latched mode's signal
// - full: 14 address, 24 data, top 8 byte address
// - host: 16-bit mux bus, A0, 16 data
// - host port takes write, read, latch, select
// - acknowledge open-drain, set by strap D
// - irq pins stay flags concurrently
// - unmasked pin assertion always requests its vector
// - general and both serial_port_b irqs programmable edge/level, others fixed
// - control register turns serial_port_b into irq/flags
// - clock_out_disable stops the clock output
// - powerdown request in, acknowledge out
// - request AND mask, highest priority chosen
// - edge pin request forced and cleared
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module dpm_pin_mux
	import dpm_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 srst,
	// register port
	input  wire logic [3:0]           reg_addr,
	input  wire logic [DPM_DW-1:0]    reg_wdata,
	input  wire logic                 reg_write,
	input  wire logic                 reg_read,
	output logic      [DPM_DW-1:0]    reg_rdata,
	output logic                      irq_out,
	// core side of the memory interface
	input  wire logic [13:0]          mem_addr,
	input  wire logic [23:0]          mem_wdata,
	input  wire logic                 mem_drive,
	input  wire logic                 byte_dma_active,
	input  wire logic [7:0]           byte_dma_addr,
	output logic      [23:0]          mem_rdata,
	output logic                      byte_dma_enable,
	output logic                      host_dma_enable,
	output logic                      mode_host,
	// core side of the host_dma_port
	input  wire logic [15:0]          host_ad_wdata,
	input  wire logic                 host_ad_drive,
	input  wire logic                 host_ack_ready,
	output logic      [15:0]          host_ad_rdata,
	output logic                      host_write_n,
	output logic                      host_read_n,
	output logic                      host_latch,
	output logic                      host_select_n,
	// core side of serial_port_b and power control
	input  wire logic                 sb_dt_core,
	output logic                      sb_rfs_core,
	output logic                      sb_tfs_core,
	output logic                      sb_dr_core,
	input  wire logic                 powered_down,
	output logic                      powerdown_req,
	output logic      [2:0]           irq_vector,
	output logic                      irq_vector_valid,
	output logic                      clock_out_enable,
	// pins: address, data, flags
	input  wire logic [13:0]          addr_pin_in,
	output logic      [13:0]          addr_pin_out,
	output logic      [13:0]          addr_pin_oe,
	input  wire logic [23:0]          data_pin_in,
	output logic      [23:0]          data_pin_out,
	output logic      [23:0]          data_pin_oe,
	input  wire logic [7:0]           pf_pin_in,
	output logic      [7:0]           pf_pin_out,
	output logic      [7:0]           pf_pin_oe,
	input  wire logic                 sb_rfs_pin,
	input  wire logic                 sb_tfs_pin,
	input  wire logic                 sb_dr_pin,
	output logic                      sb_dt_pin,
	input  wire logic                 powerdown_request_n,
	output logic                      powerdown_ack,
	output logic      [2:0]           output_flag_pins
);
	logic [DPM_SYNC_W-1:0] sync_in;       // raw pins into the synchroniser
	logic [DPM_SYNC_W-1:0] sync_out;      // synchronised pins
	logic [7:0]            pf_s;          // programmable_flags, synchronised
	logic [13:0]           addr_s;        // address pins, synchronised
	logic [23:0]           data_s;        // data pins, synchronised
	logic                  rfs_s;         // rfs / irq0 pin
	logic                  tfs_s;         // tfs / irq1 pin
	logic                  dr_s;          // dr / flag_in pin
	logic                  pwd_s;         // powerdown request, active low
	logic [3:0]            strap_shadow;  // straps seen during reset
	logic                  srst_q;        // reset delayed one cycle
	dpm_mode_t             mode;          // latched operating mode
	logic                  strap_d;       // latched acknowledge configuration
	logic [DPM_DW-1:0]     sysctl;        // serial_port_b configuration
	logic [DPM_DW-1:0]     autobuf;       // clock_out_disable lives here
	logic [7:0]            pf_dir;        // 1 = flag drives its pin
	logic [7:0]            pf_data;       // flag output values
	logic [3:0]            outflag;       // output flags and flag_out
	logic [DPM_NIRQ-1:0]   interrupt_mask_reg; // request enables
	logic [2:0]            ictrl;         // edge-sensitive selects
	logic [DPM_NIRQ-1:0]   irq_status;    // sticky requests
	logic [DPM_NIRQ-1:0]   irq_set;       // requests arriving this cycle
	logic [DPM_NIRQ-1:0]   irq_clr;       // clears issued this cycle
	logic [DPM_NIRQ-1:0]   next_status;   // status after this edge
	logic [DPM_NIRQ-1:0]   req_prev;      // previous request levels for edges
	logic [DPM_NIRQ-1:0]   req_lvl;       // request levels, active high
	logic [DPM_NIRQ-1:0]   pending;       // unmasked requests
	logic [2:0]            next_vector;   // highest priority unmasked index
	logic                  sb_flag_mode;  // serial_port_b used as irq/flags
	logic                  wr_hit_force;  // write to the force register
	logic                  host_sel;      // host mode decode

	// all foreign inputs pass two flops before use
	assign sync_in = {powerdown_request_n, sb_dr_pin, sb_tfs_pin, sb_rfs_pin,
		pf_pin_in, data_pin_in, addr_pin_in};
	dpm_sync #(.W(DPM_SYNC_W)) u_sync (
		.clock (clock),
		.d_in  (sync_in),
		.q_out (sync_out)
	);
	assign addr_s = sync_out[13:0];
	assign data_s = sync_out[37:14];
	assign pf_s   = sync_out[45:38];
	assign rfs_s  = sync_out[46];
	assign tfs_s  = sync_out[47];
	assign dr_s   = sync_out[48];
	assign pwd_s  = sync_out[49];

	assign host_sel     = (mode == DPM_HOST);
	assign sb_flag_mode = sysctl[0];
	assign wr_hit_force = reg_write && (reg_addr == DPM_REG_IFORCE);

	// straps are watched only while reset is held
	always_ff @(posedge clock) begin
		srst_q <= srst;
		if (srst) begin
			strap_shadow <= pf_s[3:0];
		end
	end

	// mode register loads once, as reset is released
	always_ff @(posedge clock) begin
		if (srst_q && !srst) begin
			mode    <= strap_shadow[DPM_STRAP_C] ? DPM_HOST : DPM_FULL;
			strap_d <= strap_shadow[DPM_STRAP_D];
		end else if (srst && !srst_q && (mode != DPM_HOST) && (mode != DPM_FULL)) begin
			mode    <= DPM_FULL; // first reset gives a legal code before release
			strap_d <= 1'b0;
		end
	end

	// software writable control registers
	always_ff @(posedge clock) begin
		if (srst) begin
			sysctl             <= DPM_RST_REG;
			autobuf            <= DPM_RST_REG;
			pf_dir             <= DPM_RST_PF;
			pf_data            <= DPM_RST_PF;
			outflag            <= 4'h0;
			interrupt_mask_reg <= DPM_RST_IRQ;
			ictrl              <= 3'h0;
		end else if (reg_write) begin
			unique case (reg_addr)
				DPM_REG_SYSCTL:  sysctl             <= reg_wdata;
				DPM_REG_AUTOBUF: autobuf            <= reg_wdata;
				DPM_REG_PF_DIR:  pf_dir             <= reg_wdata[7:0];
				DPM_REG_PF_DATA: pf_data            <= reg_wdata[7:0];
				DPM_REG_OUTFLAG: outflag            <= reg_wdata[3:0];
				DPM_REG_INTERRUPT_MASK_REG:   interrupt_mask_reg <= reg_wdata[DPM_NIRQ-1:0];
				DPM_REG_ICTRL:   ictrl              <= reg_wdata[2:0];
				default: ;
			endcase
		end
	end

	// request levels read from the pad, so self-driven flags also interrupt
	always_comb begin
		req_lvl = '0;
		req_lvl[DPM_IRQ_GEN]  = !pf_s[DPM_PF_GEN];
		req_lvl[DPM_IRQ_LVL1] = !pf_s[DPM_PF_LVL1];
		req_lvl[DPM_IRQ_LVL0] = !pf_s[DPM_PF_LVL0];
		req_lvl[DPM_IRQ_EDGE] = !pf_s[DPM_PF_EDGE];
		req_lvl[DPM_IRQ_SB1]  = sb_flag_mode && !tfs_s;
		req_lvl[DPM_IRQ_SB0]  = sb_flag_mode && !rfs_s;
		req_lvl[DPM_IRQ_PWD]  = !pwd_s;
	end

	// sets per source: edge, level, or software force
	always_comb begin
		irq_set = req_lvl & ~req_prev; // falling pin edges
		irq_set[DPM_IRQ_LVL1] = req_lvl[DPM_IRQ_LVL1];
		irq_set[DPM_IRQ_LVL0] = req_lvl[DPM_IRQ_LVL0];
		if (!ictrl[DPM_ICTRL_GEN]) begin
			irq_set[DPM_IRQ_GEN] = req_lvl[DPM_IRQ_GEN];
		end
		if (!ictrl[DPM_ICTRL_SB0]) begin
			irq_set[DPM_IRQ_SB0] = req_lvl[DPM_IRQ_SB0];
		end
		if (!ictrl[DPM_ICTRL_SB1]) begin
			irq_set[DPM_IRQ_SB1] = req_lvl[DPM_IRQ_SB1];
		end
		if (wr_hit_force && reg_wdata[DPM_IFORCE_SET]) begin
			irq_set[DPM_IRQ_EDGE] = 1'b1;
		end
		irq_clr = '0;
		if (reg_read && (reg_addr == DPM_REG_ISTATUS)) begin
			irq_clr = '1;
		end
		if (wr_hit_force && reg_wdata[DPM_IFORCE_CLR]) begin
			irq_clr[DPM_IRQ_EDGE] = 1'b1;
		end
		next_status = (irq_status & ~irq_clr) | irq_set; // set beats clear
	end

	// sticky status and edge history
	always_ff @(posedge clock) begin
		if (srst) begin
			irq_status <= DPM_RST_IRQ;
			req_prev   <= DPM_RST_IRQ;
		end else begin
			irq_status <= next_status;
			req_prev   <= req_lvl;
		end
	end

	// mask and pick the highest priority request, lowest index first
	always_comb begin
		pending     = irq_status & interrupt_mask_reg;
		next_vector = 3'h0;
		for (int k = DPM_NIRQ - 1; k >= 0; k--) begin
			if (pending[k]) begin
				next_vector = k[2:0];
			end
		end
	end

	// interrupt outputs
	always_ff @(posedge clock) begin
		if (srst) begin
			irq_out          <= 1'b0;
			irq_vector       <= 3'h0;
			irq_vector_valid <= 1'b0;
		end else begin
			irq_out          <= |pending;
			irq_vector       <= next_vector;
			irq_vector_valid <= |pending;
		end
	end

	// register read, data one cycle later
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= DPM_RST_REG;
		end else if (reg_read) begin
			unique case (reg_addr)
				DPM_REG_MODE:    reg_rdata <= {7'h00, dr_s, 3'h0, strap_d, strap_shadow[2:0], host_sel};
				DPM_REG_SYSCTL:  reg_rdata <= sysctl;
				DPM_REG_AUTOBUF: reg_rdata <= autobuf;
				DPM_REG_PF_DIR:  reg_rdata <= {8'h00, pf_dir};
				DPM_REG_PF_DATA: reg_rdata <= {8'h00, pf_s};
				DPM_REG_OUTFLAG: reg_rdata <= {12'h000, outflag};
				DPM_REG_INTERRUPT_MASK_REG:   reg_rdata <= {9'h000, interrupt_mask_reg};
				DPM_REG_ICTRL:   reg_rdata <= {13'h0000, ictrl};
				DPM_REG_ISTATUS: reg_rdata <= {9'h000, irq_status};
				default:         reg_rdata <= DPM_RST_REG;
			endcase
		end else begin
			reg_rdata <= DPM_RST_REG;
		end
	end

	// shared address and data pins follow the latched mode only
	always_ff @(posedge clock) begin
		if (srst) begin
			addr_pin_out <= 14'h0000;
			addr_pin_oe  <= 14'h0000;
			data_pin_out <= 24'h000000;
			data_pin_oe  <= 24'h000000;
		end else if (host_sel) begin
			addr_pin_out    <= {host_ad_wdata[12:0], mem_addr[0]};
			addr_pin_oe     <= {{13{host_ad_drive}}, mem_drive};
			data_pin_out    <= {mem_wdata[23:8], 8'h00};
			data_pin_oe     <= {{16{mem_drive}}, 8'h00};
			data_pin_out[2:0] <= host_ad_wdata[15:13];
			data_pin_oe[2:0]  <= {3{host_ad_drive}};
			data_pin_oe[3]    <= strap_d ? host_ack_ready : !host_ack_ready;
		end else begin
			addr_pin_out <= mem_addr;
			addr_pin_oe  <= {14{mem_drive}};
			data_pin_out <= byte_dma_active ? {byte_dma_addr, mem_wdata[15:0]} : mem_wdata;
			data_pin_oe  <= {{8{mem_drive || byte_dma_active}}, {16{mem_drive}}};
		end
	end

	// core views of the shared pins
	always_ff @(posedge clock) begin
		if (srst) begin
			mem_rdata       <= 24'h000000;
			host_ad_rdata   <= 16'h0000;
			host_write_n    <= 1'b1;
			host_read_n     <= 1'b1;
			host_latch      <= 1'b0;
			host_select_n   <= 1'b1;
			byte_dma_enable <= 1'b0;
			host_dma_enable <= 1'b0;
			mode_host       <= 1'b0;
		end else begin
			mem_rdata       <= host_sel ? {data_s[23:8], 8'h00} : data_s;
			host_ad_rdata   <= host_sel ? {data_s[2:0], addr_s[13:1]} : 16'h0000;
			host_write_n    <= host_sel ? data_s[7] : 1'b1;
			host_read_n     <= host_sel ? data_s[6] : 1'b1;
			host_latch      <= host_sel ? data_s[5] : 1'b0;
			host_select_n   <= host_sel ? data_s[4] : 1'b1;
			byte_dma_enable <= !host_sel;
			host_dma_enable <= host_sel;
			mode_host       <= host_sel;
		end
	end

	// flags, serial_port_b, clock and power pins
	always_ff @(posedge clock) begin
		if (srst) begin
			pf_pin_out       <= DPM_RST_PF;
			pf_pin_oe        <= DPM_RST_PF;
			sb_dt_pin        <= 1'b1;
			sb_rfs_core      <= 1'b1;
			sb_tfs_core      <= 1'b1;
			sb_dr_core       <= 1'b1;
			clock_out_enable <= 1'b1;
			powerdown_req    <= 1'b0;
			powerdown_ack    <= 1'b0;
		end else begin
			pf_pin_out       <= pf_data;
			pf_pin_oe        <= pf_dir;
			sb_dt_pin        <= sb_flag_mode ? outflag[DPM_OUTFLAG_FO] : sb_dt_core;
			sb_rfs_core      <= sb_flag_mode ? 1'b1 : rfs_s;
			sb_tfs_core      <= sb_flag_mode ? 1'b1 : tfs_s;
			sb_dr_core       <= sb_flag_mode ? 1'b1 : dr_s;
			clock_out_enable <= !autobuf[0];
			powerdown_req    <= !pwd_s;
			powerdown_ack    <= powered_down;
		end
	end

	assign output_flag_pins = outflag[2:0];

	AST_MODE_HOLD: assert property (@(posedge clock) disable iff (srst)
		!srst_q |=> $stable(mode)) else $error("mode changed outside reset");
	AST_MODE_LOAD: assert property (@(posedge clock) disable iff (srst)
		$fell(srst) |=> (mode == ($past(strap_shadow[DPM_STRAP_C]) ? DPM_HOST : DPM_FULL)))
		else $error("mode not taken from strap C");
	AST_STRAP_QUIET: assert property (@(posedge clock) srst |=> (pf_pin_oe == 8'h00))
		else $error("flag pins driven during reset");
	AST_FULL_NO_HOST: assert property (@(posedge clock) disable iff (srst)
		(mode == DPM_FULL) |=> (host_write_n && host_select_n && (!data_pin_oe[3] || $past(mem_drive))))
		else $error("host signals active in full mode");
	AST_FULL_ADDR: assert property (@(posedge clock) disable iff (srst)
		(mode == DPM_FULL) && mem_drive |=> (addr_pin_oe == 14'h3FFF) && (addr_pin_out == $past(mem_addr)))
		else $error("address bus not driven in full mode");
	AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (srst)
		|(irq_status & interrupt_mask_reg) |=> irq_out && irq_vector_valid)
		else $error("unmasked request without interrupt");
	sequence s_edge_fall;
		!pf_s[DPM_PF_EDGE] && req_prev[DPM_IRQ_EDGE] == 1'b0;
	endsequence
	AST_EDGE_SET: assert property (@(posedge clock) disable iff (srst)
		s_edge_fall ##0 1'b1 |=> irq_status[DPM_IRQ_EDGE])
		else $error("edge pin request lost");
	AST_CLKOUT: assert property (@(posedge clock) disable iff (srst)
		autobuf[0] |=> !clock_out_enable) else $error("clock output not disabled");
	AST_SB_FO: assert property (@(posedge clock) disable iff (srst)
		sb_flag_mode |=> (sb_dt_pin == $past(outflag[DPM_OUTFLAG_FO])))
		else $error("flag_out not on serial pin");
	AST_PWD: assert property (@(posedge clock) disable iff (srst)
		!pwd_s |=> powerdown_req) else $error("powerdown request not passed");
endmodule
`default_nettype wire

// >>> hw/dpm_pkg.sv
// constants, register map and mode type for the pin and mode multiplexer
package dpm_pkg;
	// register indices on the plain register port
	localparam logic [3:0] DPM_REG_MODE     = 4'h0;  // latched straps, flag_in readback
	localparam logic [3:0] DPM_REG_SYSCTL   = 4'h1;  // serial_port_b configuration
	localparam logic [3:0] DPM_REG_AUTOBUF  = 4'h2;  // serial_port_a autobuffer control
	localparam logic [3:0] DPM_REG_PF_DIR   = 4'h3;  // programmable flag direction
	localparam logic [3:0] DPM_REG_PF_DATA  = 4'h4;  // flag output value / pin readback
	localparam logic [3:0] DPM_REG_OUTFLAG  = 4'h5;  // output flag pins and flag_out
	localparam logic [3:0] DPM_REG_INTERRUPT_MASK_REG    = 4'h6;  // interrupt_mask_reg
	localparam logic [3:0] DPM_REG_ICTRL    = 4'h7;  // edge or level selection
	localparam logic [3:0] DPM_REG_IFORCE   = 4'h8;  // force / clear of the edge pin request
	localparam logic [3:0] DPM_REG_ISTATUS  = 4'h9;  // sticky requests, read clears
	// widths
	localparam int DPM_DW     = 16;  // register data width
	localparam int DPM_NIRQ   = 7;   // interrupt sources
	localparam int DPM_NPF    = 8;   // programmable flag pins
	localparam int DPM_AW_PIN = 14;  // address pins
	localparam int DPM_DW_PIN = 24;  // data pins
	localparam int DPM_SYNC_W = 50;  // pins passed through the synchroniser
	// field positions
	localparam int DPM_STRAP_C    = 2;   // host-mode strap within programmable_flags
	localparam int DPM_STRAP_D    = 3;   // acknowledge configuration strap
	localparam int DPM_PF_EDGE    = 4;   // edge_irq_pin
	localparam int DPM_PF_LVL0    = 5;   // level_irq_pin_0
	localparam int DPM_PF_LVL1    = 6;   // level_irq_pin_1
	localparam int DPM_PF_GEN     = 7;   // general_irq_pin
	localparam int DPM_MODE_FI    = 8;   // flag_in readback bit of the mode register
	localparam int DPM_IRQ_GEN    = 0;   // status bits, highest priority first
	localparam int DPM_IRQ_LVL1   = 1;
	localparam int DPM_IRQ_LVL0   = 2;
	localparam int DPM_IRQ_EDGE   = 3;
	localparam int DPM_IRQ_SB1    = 4;
	localparam int DPM_IRQ_SB0    = 5;
	localparam int DPM_IRQ_PWD    = 6;
	localparam int DPM_ICTRL_GEN  = 0;   // general pin edge-sensitive
	localparam int DPM_ICTRL_SB0  = 1;
	localparam int DPM_ICTRL_SB1  = 2;
	localparam int DPM_IFORCE_SET = 0;
	localparam int DPM_IFORCE_CLR = 1;
	localparam int DPM_OUTFLAG_FO = 3;
	// reset values
	localparam logic [DPM_DW-1:0]   DPM_RST_REG  = 16'h0000;
	localparam logic [DPM_NIRQ-1:0] DPM_RST_IRQ  = 7'h00;
	localparam logic [DPM_NPF-1:0]  DPM_RST_PF   = 8'h00;
	localparam logic [3:0]          DPM_RST_STRAP = 4'h0;
	// operating mode, one-hot
	typedef enum logic [1:0] {
		DPM_FULL = 2'b01,  // full memory mode
		DPM_HOST = 2'b10   // host mode
	} dpm_mode_t;
endpackage

// >>> hw/dpm_sync.sv
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none
module dpm_sync #(
	parameter int W = 1  // bits to synchronise
) (
	input  wire logic         clock,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta;  // first stage, read only by the second

	// one pair of flops per bit; no reset, so straps reach the core while reset is held
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clock) begin
				meta[i]  <= d_in[i];
				q_out[i] <= meta[i];
			end
		end
	endgenerate
endmodule
`default_nettype wire

// >>> sim/dpm_far_side.sv
// far-side model: pad resolution, pull-ups, straps and the host's strobes
`timescale 1ns/10ps
`default_nettype none
module dpm_far_side (
	input  wire logic [13:0] addr_out,
	input  wire logic [13:0] addr_oe,
	input  wire logic [23:0] data_out,
	input  wire logic [23:0] data_oe,
	input  wire logic [7:0]  pf_out,
	input  wire logic [7:0]  pf_oe,
	input  wire logic [7:0]  pf_ext,
	input  wire logic [3:0]  host_ctl,
	output logic      [13:0] addr_in,
	output logic      [23:0] data_in,
	output logic      [7:0]  pf_in
);
	logic [23:0] data_ext;  // far-side level on undriven data lines
	// released lines show the inverse of the last value, never a stale copy
	assign addr_in = (addr_oe & addr_out) | (~addr_oe & ~addr_out);
	// host strobes sit on data 7:4, the open-drain acknowledge has a pull-up
	assign data_ext = {~data_out[23:8], host_ctl, 1'b1, ~data_out[2:0]};
	assign data_in  = (data_oe & data_out) | (~data_oe & data_ext);
	// flag pins: the device wins where it drives, else pull-ups or straps
	assign pf_in = (pf_oe & pf_out) | (~pf_oe & pf_ext);
endmodule
`default_nettype wire

// >>> sim/dpm_pin_mux_test.sv
// self-checking bench of the pin and mode multiplexer
`timescale 1ns/10ps
`default_nettype none
module dpm_pin_mux_test;
	import dpm_pkg::*;
	logic        clock, srst, reg_write, reg_read, irq_out;  // clock, reset, register strobes
	logic [3:0]  reg_addr, host_ctl;                         // register index, host strobe levels
	logic [15:0] reg_wdata, reg_rdata, host_ad_wdata, host_ad_rdata;
	logic [13:0] mem_addr, addr_pin_in, addr_pin_out, addr_pin_oe;
	logic [23:0] mem_wdata, mem_rdata, data_pin_in, data_pin_out, data_pin_oe;
	logic [7:0]  byte_dma_addr, pf_pin_in, pf_pin_out, pf_pin_oe, pf_ext;
	logic        mem_drive, byte_dma_active, byte_dma_enable, host_dma_enable, mode_host;
	logic        host_ad_drive, host_ack_ready, host_write_n, host_read_n, host_latch, host_select_n;
	logic        sb_dt_core, sb_rfs_core, sb_tfs_core, sb_dr_core, powered_down, powerdown_req;
	logic        irq_vector_valid, clock_out_enable, sb_rfs_pin, sb_tfs_pin, sb_dr_pin, sb_dt_pin;
	logic        powerdown_request_n, powerdown_ack;
	logic [2:0]  irq_vector, output_flag_pins;
	logic [3:0]  row_a [8];  // row inputs: register index
	logic [15:0] row_d [8];  // row inputs: write data
	logic [15:0] row_e [8];  // row outputs: expected read back
	int          fails, comparisons, cycles;
	// the block under test, every port by name
	dpm_pin_mux dut (.clock, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq_out,
		.mem_addr, .mem_wdata, .mem_drive, .byte_dma_active, .byte_dma_addr, .mem_rdata, .byte_dma_enable,
		.host_dma_enable, .mode_host, .host_ad_wdata, .host_ad_drive, .host_ack_ready, .host_ad_rdata,
		.host_write_n, .host_read_n, .host_latch, .host_select_n, .sb_dt_core, .sb_rfs_core, .sb_tfs_core,
		.sb_dr_core, .powered_down, .powerdown_req, .irq_vector, .irq_vector_valid, .clock_out_enable,
		.addr_pin_in, .addr_pin_out, .addr_pin_oe, .data_pin_in, .data_pin_out, .data_pin_oe, .pf_pin_in,
		.pf_pin_out, .pf_pin_oe, .sb_rfs_pin, .sb_tfs_pin, .sb_dr_pin, .sb_dt_pin, .powerdown_request_n,
		.powerdown_ack, .output_flag_pins);
	// the pads' far side
	dpm_far_side far (.addr_out(addr_pin_out), .addr_oe(addr_pin_oe), .data_out(data_pin_out),
		.data_oe(data_pin_oe), .pf_out(pf_pin_out), .pf_oe(pf_pin_oe), .pf_ext(pf_ext), .host_ctl(host_ctl),
		.addr_in(addr_pin_in), .data_in(data_pin_in), .pf_in(pf_pin_in));
	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// hang guard: the sequence needs well under a thousand cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			tally_and_finish();
		end
	end
	// verdict and end of run
	task automatic tally_and_finish();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one comparison
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// let n edges pass, then sample where outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// one-cycle register write
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	// one-cycle register read, data taken in the cycle after
	task automatic rdc(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	// twelve reset cycles with the given strap levels on flag pins 3:0
	task automatic do_reset(input logic [3:0] strap);
		pf_ext <= {4'hF, strap};
		srst   <= 1'b1;
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		cyc(2);
	endtask
	// main sequence
	initial begin
		{reg_write, reg_read, reg_addr, reg_wdata, mem_drive, byte_dma_active, host_ad_drive} = '0;
		{host_ack_ready, sb_dt_core, powered_down, fails, comparisons, cycles} = '0;
		{mem_addr, mem_wdata, byte_dma_addr} = {14'h2A5C, 24'h123456, 8'h9B};
		{sb_rfs_pin, sb_tfs_pin, sb_dr_pin, powerdown_request_n, host_ctl} = {4'hF, 4'h5};
		host_ad_wdata = 16'hB5A3;
		row_a = '{DPM_REG_PF_DIR, DPM_REG_SYSCTL, DPM_REG_AUTOBUF, DPM_REG_OUTFLAG, DPM_REG_INTERRUPT_MASK_REG,
			DPM_REG_ICTRL, 4'hF, DPM_REG_ISTATUS};
		row_d = '{16'h000F, 16'h0001, 16'h0001, 16'h0005, 16'h007F, 16'h0006, 16'hA5A5, 16'h007F};
		row_e = '{16'h000F, 16'h0001, 16'h0001, 16'h0005, 16'h007F, 16'h0006, 16'h0000, 16'h0000};
		// full memory mode after a low strap C
		do_reset(4'h0);
		chk({mode_host, byte_dma_enable, host_dma_enable}, 3'b010);
		rdc(DPM_REG_MODE, 16'h0100);
		pf_ext <= 8'hF4;
		cyc(4);
		chk(mode_host, 1'b0);
		rdc(DPM_REG_MODE, 16'h0100);
		// register rows
		for (int i = 0; i < 8; i++) begin
			wr(row_a[i], row_d[i]);
			rdc(row_a[i], row_e[i]);
		end
		{sb_dr_pin, sb_dt_core} <= 2'b01;
		cyc(4);
		chk({clock_out_enable, output_flag_pins, sb_dr_core, sb_dt_pin}, 6'b0_101_1_0);
		wr(DPM_REG_SYSCTL, 16'h0000);
		wr(DPM_REG_AUTOBUF, 16'h0000);
		cyc(4);
		chk({clock_out_enable, sb_dr_core, sb_dt_pin}, 3'b101);
		sb_dr_pin <= 1'b1;
		// full-mode address and data pins, byte address on the top eight
		{mem_drive, byte_dma_active} <= 2'b11;
		cyc(4);
		chk(addr_pin_out, 14'h2A5C);
		chk(addr_pin_oe, 14'h3FFF);
		chk(data_pin_out, 24'h9B3456);
		chk(data_pin_oe, 24'hFFFFFF);
		chk(mem_rdata, 24'h9B3456);
		// a flag driven low by software raises the edge request
		wr(DPM_REG_PF_DATA, 16'h0000);
		wr(DPM_REG_PF_DIR, 16'h001F);
		cyc(6);
		chk({pf_pin_oe[4], pf_pin_out[4]}, 2'b10);
		chk({irq_out, irq_vector_valid, irq_vector}, {2'b11, 3'(DPM_IRQ_EDGE)});
		rdc(DPM_REG_ISTATUS, 16'h0008);
		rdc(DPM_REG_ISTATUS, 16'h0000);
		// two level pins at once: priority, then masking
		pf_ext <= 8'h54;
		cyc(6);
		chk(irq_vector, 3'(DPM_IRQ_GEN));
		wr(DPM_REG_INTERRUPT_MASK_REG, 16'h007E);
		cyc(3);
		chk(irq_vector, 3'(DPM_IRQ_LVL0));
		pf_ext <= 8'hF4;
		cyc(4);
		rdc(DPM_REG_ISTATUS, 16'h0005);
		rdc(DPM_REG_ISTATUS, 16'h0000);
		// general pin switched to edge-sensitive
		wr(DPM_REG_ICTRL, 16'h0001);
		wr(DPM_REG_INTERRUPT_MASK_REG, 16'h007F);
		pf_ext <= 8'h74;
		cyc(6);
		rdc(DPM_REG_ISTATUS, 16'h0001);
		rdc(DPM_REG_ISTATUS, 16'h0000);
		pf_ext <= 8'hF4;
		// edge request forced, then cleared
		wr(DPM_REG_IFORCE, 16'h0001);
		cyc(3);
		chk({irq_out, irq_vector}, {1'b1, 3'(DPM_IRQ_EDGE)});
		wr(DPM_REG_IFORCE, 16'h0002);
		cyc(3);
		chk(irq_out, 1'b0);
		// power-down handshake
		{powerdown_request_n, powered_down} <= 2'b01;
		cyc(5);
		chk({powerdown_req, powerdown_ack, irq_vector}, {2'b11, 3'(DPM_IRQ_PWD)});
		{powerdown_request_n, powered_down} <= 2'b10;
		rdc(DPM_REG_ISTATUS, 16'h0040);
		// host mode after a high strap C
		{host_ad_drive, byte_dma_active} <= 2'b10;
		do_reset(4'h4);
		cyc(3);
		chk({mode_host, byte_dma_enable, host_dma_enable}, 3'b101);
		rdc(DPM_REG_MODE, 16'h0109);
		chk(addr_pin_out, 14'h2B46);
		chk({data_pin_out[23:8], data_pin_out[2:0], data_pin_oe[7:4]}, {16'h1234, 3'h5, 4'h0});
		chk({host_ad_rdata, mem_rdata[7:0]}, {16'hB5A3, 8'h00});
		chk({host_write_n, host_read_n, host_latch, host_select_n}, 4'b0101);
		chk({data_pin_oe[3], data_pin_out[3]}, 2'b10);
		host_ack_ready <= 1'b1;
		cyc(3);
		chk({data_pin_oe[3], data_pin_out[3]}, 2'b00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
